// ### include/abs_xfer_map.svh
// Constants for the absolute position transfer controller
`ifndef ABS_XFER_MAP_SVH
`define ABS_XFER_MAP_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define ABS_CLK_PERIOD_NS 4
`define ABS_READ_DELAY_NS 10000000
`define ABS_READ_DELAY_CYC (`ABS_READ_DELAY_NS / `ABS_CLK_PERIOD_NS)
`define ABS_MODE_TMO_CYC 250000000
`define ABS_REQ_TMO_CYC 25000000
`define ABS_RTS_TMO_CYC 25000000
`define ABS_RETRY_WAIT_CYC 25000000
// ****************************************************************
// Frame layout
// ****************************************************************
`define ABS_DATA_STEPS 5'h10
`define ABS_TOTAL_STEPS 5'h13
`define ABS_MAX_RETRY 2'h3
`define ABS_UNIT_PULSE 2'h3
`define ABS_POS_RESET 32'h0000_0000
`endif

// ### include/abs_xfer_pkg.sv
// Types for the absolute position transfer controller
package abs_xfer_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_MODE = 8'h02,
    ST_REQ = 8'h04,
    ST_ACK = 8'h08,
    ST_DELAY = 8'h10,
    ST_CHECK = 8'h20,
    ST_RETRY = 8'h40,
    ST_DONE = 8'h80
  } xfer_state_t;

  typedef struct packed {
    logic servo_on;
    logic transfer_mode;
    logic position_request;
    logic comm_error;
    logic checksum_error;
    logic coordinate_error;
    logic position_data_ready_flag;
    logic move_start;
  } host_pins_t;

  typedef struct packed {
    xfer_state_t state;
    host_pins_t pins;
    logic [31:0] position;
    logic [5:0] sum_rx;
    logic [5:0] sum_acc;
    logic [4:0] step;
    logic [1:0] retry_counter;
    logic [1:0] two_bit_receive_buffer;
    logic [15:0] pos_lo;
    logic [15:0] pos_hi;
    logic prev_servo_cmd;
    logic prev_run;
    logic prev_power;
  } host_state_t;
endpackage

// ### rtl/absolute_position_transfer_host.sv
// Controller reading absolute position from a servo amplifier over I/O pins
// ****************************************************************
// Functional notes
// - Servo-on off-to-on transition starts a transfer.
// - With servo-on tied, start at amplifier power-up and run rising edge.
// - Alarm clear or emergency stop release starts a fresh transfer.
// - Check sum mismatch repeats whole transfer, up to three retries.
// - Mismatch after last retry raises check sum error, retries stop.
// - Time mode on, request on, ready off; overrun raises comm error.
// - Sign with direction setting giving negative coordinate raises error.
// - Capture two bits per step in buffer, shift into position word.
// - Hold position as 32 bits split in lower and upper halves.
// - Wait fixed delay after data ready before sampling bits.
// - Length units multiply position by travel-per-pulse constant.
// - Pulse unit uses received position without scaling.
// - Motion start is inhibited while data ready flag is low.
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "abs_xfer_map.svh"
module absolute_position_transfer_host
#(
  parameter logic [31:0] READ_DELAY_CYC = `ABS_READ_DELAY_CYC,
  parameter logic [31:0] MODE_TMO_CYC = `ABS_MODE_TMO_CYC,
  parameter logic [31:0] REQ_TMO_CYC = `ABS_REQ_TMO_CYC,
  parameter logic [31:0] RTS_TMO_CYC = `ABS_RTS_TMO_CYC,
  parameter logic [31:0] RETRY_WAIT_CYC = `ABS_RETRY_WAIT_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic servo_on_cmd_in,
  input wire logic servo_tied_in,
  input wire logic amp_power_in,
  input wire logic run_in,
  input wire logic alarm_clear_in,
  input wire logic estop_release_in,
  input wire logic ready_to_send_in,
  input wire logic data_bit0_in,
  input wire logic data_bit1_in,
  input wire logic [1:0] unit_setting_in,
  input wire logic [6:0] scale_k_in,
  input wire logic rotation_dir_in,
  input wire logic move_start_in,
  output logic servo_on_out,
  output logic transfer_mode_out,
  output logic position_request_out,
  output logic comm_error_out,
  output logic checksum_error_out,
  output logic coordinate_error_out,
  output logic position_data_ready_out,
  output logic move_start_out,
  output logic [15:0] position_lo_out,
  output logic [15:0] position_hi_out
);
  abs_xfer_pkg::host_state_t st_r;
  abs_xfer_pkg::host_state_t st_nxt;
  logic phase_clear;
  logic phase_run;
  logic [31:0] phase_limit;
  logic phase_expired;
  logic mode_expired;
  logic trigger;
  logic [31:0] product;

  // ****************************************************************
  // Timers
  // ****************************************************************
  phase_timer u_phase_timer
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(phase_clear),
    .run_in(phase_run),
    .limit_in(phase_limit),
    .expired_out(phase_expired)
  );

  phase_timer u_mode_timer
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(trigger),
    .run_in(st_r.pins.transfer_mode),
    .limit_in(MODE_TMO_CYC),
    .expired_out(mode_expired)
  );

  assign phase_clear = (st_nxt.state != st_r.state);
  assign phase_run = (st_r.state != abs_xfer_pkg::ST_IDLE)
    && (st_r.state != abs_xfer_pkg::ST_DONE);

  always_comb
  begin
    case (st_r.state)
      abs_xfer_pkg::ST_REQ: phase_limit = REQ_TMO_CYC;
      abs_xfer_pkg::ST_ACK: phase_limit = RTS_TMO_CYC;
      abs_xfer_pkg::ST_DELAY: phase_limit = READ_DELAY_CYC;
      abs_xfer_pkg::ST_RETRY: phase_limit = RETRY_WAIT_CYC;
      default: phase_limit = MODE_TMO_CYC;
    endcase
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  // Any start event restarts the transfer, even one already running
  assign trigger = (servo_on_cmd_in && !st_r.prev_servo_cmd)
    || (servo_tied_in && amp_power_in && !st_r.prev_power)
    || (servo_tied_in && run_in && !st_r.prev_run)
    || alarm_clear_in || estop_release_in;

  assign product = st_r.position * {25'h0, scale_k_in};

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev_servo_cmd = servo_on_cmd_in;
    st_nxt.prev_run = run_in;
    st_nxt.prev_power = amp_power_in;
    st_nxt.pins.servo_on = servo_on_cmd_in || servo_tied_in;
    st_nxt.pins.move_start = move_start_in
      && st_r.pins.position_data_ready_flag;
    if (!st_nxt.pins.servo_on)
    begin
      st_nxt.pins.position_data_ready_flag = 1'b0;
    end
    case (st_r.state)
      abs_xfer_pkg::ST_IDLE:
      begin
        st_nxt.pins.transfer_mode = 1'b0;
        st_nxt.pins.position_request = 1'b0;
      end
      abs_xfer_pkg::ST_MODE:
      begin
        // Amplifier raises ready once it has entered transfer mode
        if (ready_to_send_in)
        begin
          st_nxt.state = abs_xfer_pkg::ST_REQ;
          st_nxt.pins.position_request = 1'b1;
        end
      end
      abs_xfer_pkg::ST_REQ:
      begin
        if (phase_expired)
        begin
          st_nxt.pins.comm_error = 1'b1;
          st_nxt.state = abs_xfer_pkg::ST_IDLE;
        end
        else if (!ready_to_send_in)
        begin
          st_nxt.state = abs_xfer_pkg::ST_ACK;
        end
      end
      abs_xfer_pkg::ST_ACK:
      begin
        if (phase_expired)
        begin
          st_nxt.pins.comm_error = 1'b1;
          st_nxt.state = abs_xfer_pkg::ST_IDLE;
        end
        else if (ready_to_send_in)
        begin
          st_nxt.state = abs_xfer_pkg::ST_DELAY;
        end
      end
      abs_xfer_pkg::ST_DELAY:
      begin
        if (phase_expired)
        begin
          st_nxt.two_bit_receive_buffer =
            {data_bit1_in, data_bit0_in};
          if (st_r.step < `ABS_DATA_STEPS)
          begin
            // Lowest bit pair arrives first
            st_nxt.position = {data_bit1_in, data_bit0_in,
              st_r.position[31:2]};
            st_nxt.sum_acc = st_r.sum_acc
              + {4'h0, data_bit1_in, data_bit0_in};
          end
          else
          begin
            st_nxt.sum_rx = {data_bit1_in, data_bit0_in,
              st_r.sum_rx[5:2]};
          end
          st_nxt.step = st_r.step + 5'h1;
          if (st_r.step == `ABS_TOTAL_STEPS - 5'h1)
          begin
            st_nxt.pins.position_request = 1'b0;
            st_nxt.state = abs_xfer_pkg::ST_CHECK;
          end
          else
          begin
            st_nxt.state = abs_xfer_pkg::ST_REQ;
          end
        end
      end
      abs_xfer_pkg::ST_CHECK:
      begin
        st_nxt.pins.transfer_mode = 1'b0;
        if (st_r.sum_rx == st_r.sum_acc)
        begin
          st_nxt.state = abs_xfer_pkg::ST_DONE;
        end
        else if (st_r.retry_counter != `ABS_MAX_RETRY)
        begin
          st_nxt.retry_counter = st_r.retry_counter + 2'h1;
          st_nxt.state = abs_xfer_pkg::ST_RETRY;
        end
        else
        begin
          st_nxt.pins.checksum_error = 1'b1;
          st_nxt.state = abs_xfer_pkg::ST_IDLE;
        end
      end
      abs_xfer_pkg::ST_RETRY:
      begin
        if (phase_expired)
        begin
          st_nxt.state = abs_xfer_pkg::ST_MODE;
          st_nxt.pins.transfer_mode = 1'b1;
          st_nxt.step = 5'h0;
          st_nxt.sum_acc = 6'h0;
          st_nxt.sum_rx = 6'h0;
        end
      end
      abs_xfer_pkg::ST_DONE:
      begin
        // Coordinate check on raw data, before any unit scaling
        if (rotation_dir_in ? (!st_r.position[31]
          && (st_r.position != 32'h0)) : st_r.position[31])
        begin
          st_nxt.pins.coordinate_error = 1'b1;
        end
        else
        begin
          if (unit_setting_in == `ABS_UNIT_PULSE)
          begin
            {st_nxt.pos_hi, st_nxt.pos_lo} = st_r.position;
          end
          else
          begin
            // Upper product bits drop; travel must fit 32 bits
            {st_nxt.pos_hi, st_nxt.pos_lo} = product[31:0];
          end
          st_nxt.pins.position_data_ready_flag = 1'b1;
        end
        st_nxt.state = abs_xfer_pkg::ST_IDLE;
      end
      default:
      begin
        st_nxt.state = abs_xfer_pkg::ST_IDLE;
      end
    endcase
    // Any overrun drops both pins at once; mode bound covers a silent amp
    if ((mode_expired && st_r.pins.transfer_mode) || (phase_expired
      && (st_r.state == abs_xfer_pkg::ST_REQ
      || st_r.state == abs_xfer_pkg::ST_ACK)))
    begin
      st_nxt.pins.comm_error = 1'b1;
      st_nxt.pins.transfer_mode = 1'b0;
      st_nxt.pins.position_request = 1'b0;
      st_nxt.state = abs_xfer_pkg::ST_IDLE;
    end
    if (st_r.state == abs_xfer_pkg::ST_RETRY)
    begin
      st_nxt.pins.transfer_mode = phase_expired;
      st_nxt.pins.position_request = 1'b0;
    end
    if (trigger)
    begin
      st_nxt.state = abs_xfer_pkg::ST_MODE;
      st_nxt.pins.transfer_mode = 1'b1;
      st_nxt.pins.position_request = 1'b0;
      st_nxt.pins.comm_error = 1'b0;
      st_nxt.pins.checksum_error = 1'b0;
      st_nxt.pins.coordinate_error = 1'b0;
      st_nxt.pins.position_data_ready_flag = 1'b0;
      st_nxt.step = 5'h0;
      st_nxt.sum_acc = 6'h0;
      st_nxt.sum_rx = 6'h0;
      st_nxt.retry_counter = 2'h0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
      st_r.state <= abs_xfer_pkg::ST_IDLE;
      st_r.position <= `ABS_POS_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign servo_on_out = st_r.pins.servo_on;
  assign transfer_mode_out = st_r.pins.transfer_mode;
  assign position_request_out = st_r.pins.position_request;
  assign comm_error_out = st_r.pins.comm_error;
  assign checksum_error_out = st_r.pins.checksum_error;
  assign coordinate_error_out = st_r.pins.coordinate_error;
  assign position_data_ready_out = st_r.pins.position_data_ready_flag;
  assign move_start_out = st_r.pins.move_start;
  assign position_lo_out = st_r.pos_lo;
  assign position_hi_out = st_r.pos_hi;
endmodule
`default_nettype wire

// ### rtl/phase_timer.sv
// Restartable phase timer with a limit compare
`timescale 1ns/10ps
`default_nettype none
module phase_timer
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic [31:0] limit_in,
  output logic expired_out
);
  logic [31:0] count_r;
  logic expired_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || clear_in || !run_in)
    begin
      count_r <= 32'h0;
      expired_r <= 1'b0;
    end
    else
    begin
      // Saturate so a stalled phase keeps reporting expiry
      if (count_r != 32'hffff_ffff)
      begin
        count_r <= count_r + 32'h1;
      end
      expired_r <= (count_r >= limit_in);
    end
  end

  assign expired_out = expired_r;
endmodule
`default_nettype wire

// ### verif/amp_model.sv
// Behavioural servo amplifier side of the position handshake
`timescale 1ns/10ps
`default_nettype none
module amp_model
(
  input wire logic clk_in,
  input wire logic mode_in,
  input wire logic req_in,
  input wire logic clr_in,
  input wire logic stall_in,
  input wire logic [2:0] bad_n_in,
  input wire logic [2:0] slow_in,
  input wire logic [31:0] pos_in,
  output logic rts_out,
  output logic b0_out,
  output logic b1_out
);
  logic [1:0] pair;
  logic [5:0] sum;
  logic live, bad;
  logic tog = 1'b0;
  int n, i, j;
  // Released pins wander so stale bits never pass
  always @(posedge clk_in)
    tog <= ~tog;
  assign b0_out = live ? pair[0] : tog;
  assign b1_out = live ? pair[1] : ~tog;
  initial
  begin
    {live, rts_out, pair} = 4'h0;
    n = 0;
    forever
    begin
      @(posedge clk_in);
      if (clr_in)
        n = 0;
      if (mode_in)
      begin
        bad = n < bad_n_in;
        n++;
        sum = 6'h0;
        rts_out <= 1'b1;
        while (mode_in && !req_in)
          @(posedge clk_in);
        for (i = 0; i < 19 && mode_in; i++)
        begin
          rts_out <= 1'b0;
          live <= 1'b0;
          repeat (2 + slow_in)
            @(posedge clk_in);
          if (i < 16)
          begin
            pair <= pos_in[2 * i +: 2];
            sum = sum + {4'h0, pos_in[2 * i +: 2]};
          end
          else
            pair <= sum[2 * (i - 16) +: 2] ^ {1'b0, bad && i == 16};
          // Stall holds ready off so the controller must give up
          while (stall_in && mode_in)
            @(posedge clk_in);
          // Skip the raise when mode fell, so ready never rises after transfer mode ends
          if (mode_in)
          begin
            live <= 1'b1;
            rts_out <= 1'b1;
          end
          for (j = 0; j < 30 && mode_in; j++)
            @(posedge clk_in);
        end
        while (mode_in)
          @(posedge clk_in);
        rts_out <= 1'b0;
        live <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/test_absolute_position_transfer_host.sv
// Self-checking bench for the absolute position transfer controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
module test_absolute_position_transfer_host;
  logic clk, rst_n, cmd, tied, pwr, run_s, alm, est, move, dir;
  logic rts, b0, b1, clr, stall, so, tm, pr, ce, se, co, pdr, ms;
  logic [1:0] unit;
  logic [6:0] k;
  logic [2:0] bad_n, slow;
  logic [31:0] apos, last;
  logic [15:0] lo, hi;
  int errors, samples_checked, t, r;
  absolute_position_transfer_host #(.READ_DELAY_CYC(32'h14),
    .MODE_TMO_CYC(32'h7d0), .REQ_TMO_CYC(32'h64), .RTS_TMO_CYC(32'h64),
    .RETRY_WAIT_CYC(32'h1e)) dut (.clk_in(clk), .rst_n_in(rst_n),
    .servo_on_cmd_in(cmd), .servo_tied_in(tied), .amp_power_in(pwr),
    .run_in(run_s), .alarm_clear_in(alm), .estop_release_in(est),
    .ready_to_send_in(rts), .data_bit0_in(b0), .data_bit1_in(b1),
    .unit_setting_in(unit), .scale_k_in(k), .rotation_dir_in(dir),
    .move_start_in(move), .servo_on_out(so), .transfer_mode_out(tm),
    .position_request_out(pr), .comm_error_out(ce),
    .checksum_error_out(se), .coordinate_error_out(co),
    .position_data_ready_out(pdr), .move_start_out(ms),
    .position_lo_out(lo), .position_hi_out(hi));
  amp_model amp (.clk_in(clk), .mode_in(tm), .req_in(pr), .clr_in(clr),
    .stall_in(stall), .bad_n_in(bad_n), .slow_in(slow), .pos_in(apos),
    .rts_out(rts), .b0_out(b0), .b1_out(b1));
  always #2 clk = ~clk;
  task end_of_test;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input int kind, input logic [31:0] p, input int bad,
    input logic stl, input logic cbad);
    int n;
    logic ok;
    @(posedge clk);
    apos <= p;
    bad_n <= 3'(bad);
    stall <= stl;
    slow <= 3'($urandom_range(6));
    unit <= 2'($urandom);
    k <= 7'($urandom_range(100, 1));
    dir <= p[31] ^ cbad;
    clr <= 1'b1;
    case (kind)
      0: cmd <= 1'b0;
      1: {cmd, tied, pwr} <= 3'b010;
      2: {cmd, tied, run_s} <= 3'b010;
      default: ;
    endcase
    repeat (3)
      @(posedge clk);
    clr <= 1'b0;
    case (kind)
      0: cmd <= 1'b1;
      1: pwr <= 1'b1;
      2: run_s <= 1'b1;
      3: alm <= 1'b1;
      default: est <= 1'b1;
    endcase
    @(posedge clk);
    {alm, est} <= 2'h0;
    for (n = 0; tm !== 1'b1 && n < 9; n++)
      @(negedge clk);
    repeat (3)
      @(negedge clk);
    // Bounded so a silent controller cannot hang the run
    for (n = 0; {pdr, ce, se, co} === 4'h0 && n < 9000; n++)
      @(negedge clk);
    repeat (2)
      @(negedge clk);
    ok = !stl && bad < 4 && !cbad;
    if (ok)
      last = (unit == 2'h3) ? p : p * {25'h0, k};
    `CHK("comm", stl, ce)
    `CHK("sum", 1'(bad > 3), se)
    `CHK("coord", 1'(cbad && !stl), co)
    `CHK("ready", ok, pdr)
    `CHK("move", ok, ms)
    `CHK("servo", cmd | tied, so)
    `CHK("pos", last, {hi, lo})
    $display("test kind %0d done", kind);
  endtask
  initial
  begin
    {clk, rst_n, cmd, tied, alm, est, dir, stall} = 8'h0;
    {pwr, run_s, move, clr} = 4'hf;
    unit = 2'h3;
    k = 7'h0a;
    {bad_n, slow} = 6'h0;
    apos = 32'h0;
    last = 32'h0;
    errors = 0;
    samples_checked = 0;
    r = $urandom(32'hfcbc);
    repeat (4)
      @(posedge clk);
    @(negedge clk);
    `CHK("reset", 40'h0, {so, tm, pr, ce, se, co, pdr, ms, hi, lo})
    @(posedge clk);
    rst_n <= 1'b1;
    for (t = 0; t < 10; t++)
      xfer(t % 5, $urandom, 0, 1'b0, 1'b0);
    xfer(3, $urandom, 3, 1'b0, 1'b0);
    xfer(0, $urandom, 4, 1'b0, 1'b0);
    xfer(4, $urandom, 0, 1'b1, 1'b0);
    xfer(1, $urandom | 32'h1, 0, 1'b0, 1'b1);
    xfer(2, $urandom, 0, 1'b0, 1'b0);
    end_of_test;
  end
  initial
  begin
    #240000;
    errors++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule
`default_nettype wire

// ### verif/xfer_checker.sv
// Port assertions for the absolute position transfer controller
`timescale 1ns/10ps
`default_nettype none
module xfer_checker
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ready_to_send_in,
  input wire logic move_start_in,
  input wire logic transfer_mode_out,
  input wire logic position_request_out,
  input wire logic comm_error_out,
  input wire logic checksum_error_out,
  input wire logic coordinate_error_out,
  input wire logic position_data_ready_out,
  input wire logic move_start_out,
  input wire logic [15:0] position_lo_out,
  input wire logic [15:0] position_hi_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ****************************************
  // Properties
  // ****************************************
  move_gate_a: assert property (
    $past(rst_n_in) |-> move_start_out ==
    ($past(move_start_in) && $past(position_data_ready_out)))
    else $error("move start not gated");
  req_in_mode_a: assert property (
    position_request_out |-> transfer_mode_out)
    else $error("request outside mode");
  req_after_ready_a: assert property (
    $rose(position_request_out) |-> $past(ready_to_send_in))
    else $error("request without ready");
  ready_clear_a: assert property (
    transfer_mode_out |=> !position_data_ready_out)
    else $error("ready flag during transfer");
  coord_blocks_a: assert property (
    coordinate_error_out |-> !position_data_ready_out)
    else $error("ready with coordinate error");
  comm_stop_a: assert property (
    $rose(comm_error_out) |-> !transfer_mode_out && !position_request_out)
    else $error("pins left up on comm error");
  sum_stop_a: assert property (
    $rose(checksum_error_out) |-> !transfer_mode_out [*2])
    else $error("retry after sum error");
  pos_hold_a: assert property (
    $changed({position_hi_out, position_lo_out}) |->
    $rose(position_data_ready_out))
    else $error("position moved without ready");
endmodule
bind absolute_position_transfer_host xfer_checker chk (.*);
`default_nettype wire
